// file: verilog/clk_regs_pkg.sv
// constants for the status readback and output zero driver control registers
package clk_regs_pkg;

  // ------------------------------------------------------------
  // register access
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W = 10;  // control port address width
  localparam int unsigned DATA_W = 8;   // every register is one byte wide

  localparam logic [ADDR_W-1:0] STATUS_ADDR   = 10'h01f;  // pll_status_readback
  localparam logic [ADDR_W-1:0] DRV_CTRL_ADDR = 10'h0f0;  // output_zero_driver_control

  // ------------------------------------------------------------
  // pll_status_readback fields
  // ------------------------------------------------------------
  localparam int unsigned ST_HOLDOVER_BIT   = 5;  // holdover state in force
  localparam int unsigned ST_REF_SEL_BIT    = 4;  // 1 = reference input two feeds the loop
  localparam int unsigned ST_VCO_HI_BIT     = 3;  // vco above its monitor threshold
  localparam int unsigned ST_REF_TWO_HI_BIT = 2;  // reference input two above threshold
  localparam int unsigned ST_REF_ONE_HI_BIT = 1;  // reference input one above threshold
  localparam int unsigned ST_LOCK_BIT       = 0;  // digital lock detect
  localparam int unsigned ST_COND_W         = 6;  // monitored conditions, bits 5:0

  // ------------------------------------------------------------
  // output_zero_driver_control fields
  // ------------------------------------------------------------
  localparam int unsigned OC_FORMAT_BIT = 7;  // 0 differential, 1 single-ended cmos
  localparam int unsigned OC_LEG_B_BIT  = 6;  // leg b drive in cmos mode
  localparam int unsigned OC_LEG_A_BIT  = 5;  // leg a drive in cmos mode
  localparam int unsigned OC_POL_HI_BIT = 4;  // polarity field, upper bit
  localparam int unsigned OC_POL_LO_BIT = 3;  // polarity field, lower bit

  // differential, both legs on, non-inverting, middle swing, powered
  localparam logic [DATA_W-1:0] DRV_CTRL_RESET = 8'h62;

  // ------------------------------------------------------------
  // synchroniser depth
  // ------------------------------------------------------------
  localparam int unsigned SYNC_STAGES = 2;

endpackage

// file: verilog/cond_sync.sv
// two flip-flop level synchroniser for a group of independent condition bits
`timescale 1ns/1ps

module cond_sync #(
  parameter int unsigned WIDTH = 6  // number of independent level bits
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ------------------------------------------------------------
  // two stages
  // ------------------------------------------------------------
  logic [WIDTH-1:0] meta_reg;  // first stage, read only by the second stage
  logic [WIDTH-1:0] sync_reg;  // second stage, safe for logic

  // each bit crosses alone; the bits are not coherent with each other
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule // cond_sync

// file: verilog/clock_status_and_output_format_regs.sv
// status readback and output zero driver control registers of the clock generator
`timescale 1ns/1ps

// Behaviour
// R1 - bit 5 reads holdover actually in force
// R2 - bit 4 reads 1 when reference two selected
// R3 - bit 3 reads vco above monitor threshold
// R4 - bit 2 reads reference two above threshold
// R5 - bit 1 reads reference one above threshold
// R6 - bit 0 reads digital lock detect result
// R7 - status is read only, writes change nothing
// R8 - control bit 7 selects differential or cmos
// R9 - bits 6:5 gate cmos legs b and a
// R10 - bits 4:3 set polarity with format bit
// R11 - status inputs pass two-stage synchronisers
module clock_status_and_output_format_regs (
  input  wire logic                              sys_clk,
  input  wire logic                              resetn,
  // control port register access
  input  wire logic [clk_regs_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [clk_regs_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  output logic      [clk_regs_pkg::DATA_W-1:0]  reg_rdata,
  output logic                                   reg_rvalid,
  // monitored conditions from the pll core, asynchronous levels
  input  wire logic                              holdover_active_in,
  input  wire logic                              ref_two_selected_in,
  input  wire logic                              vco_above_thresh_in,
  input  wire logic                              ref_two_above_thresh_in,
  input  wire logic                              ref_one_above_thresh_in,
  input  wire logic                              pll_locked_in,
  // clock_output_zero driver controls
  output logic                                   output_zero_cmos_mode,
  output logic                                   output_zero_diff_enable,
  output logic                                   output_zero_leg_a_enable,
  output logic                                   output_zero_leg_b_enable,
  output logic                                   output_zero_leg_a_invert,
  output logic                                   output_zero_leg_b_invert
);

  // ------------------------------------------------------------
  // condition synchronisers
  // ------------------------------------------------------------
  logic [clk_regs_pkg::ST_COND_W-1:0] cond_raw;   // condition levels as they arrive
  logic [clk_regs_pkg::ST_COND_W-1:0] cond_synced;  // conditions in the sys_clk domain

  // gather the conditions in their status bit positions
  always_comb begin
    cond_raw                                = '0;
    cond_raw[clk_regs_pkg::ST_HOLDOVER_BIT] = holdover_active_in;
    cond_raw[clk_regs_pkg::ST_REF_SEL_BIT]  = ref_two_selected_in;
    cond_raw[clk_regs_pkg::ST_VCO_HI_BIT]   = vco_above_thresh_in;
    cond_raw[clk_regs_pkg::ST_REF_TWO_HI_BIT] = ref_two_above_thresh_in;
    cond_raw[clk_regs_pkg::ST_REF_ONE_HI_BIT] = ref_one_above_thresh_in;
    cond_raw[clk_regs_pkg::ST_LOCK_BIT]     = pll_locked_in;
  end

  // R11 two stages per monitored level
  cond_sync #(
    .WIDTH (clk_regs_pkg::ST_COND_W)
  ) u_cond_sync (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .async_in (cond_raw),
    .sync_out (cond_synced)
  );

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  // one comparator shared by read and write paths
  function automatic logic hit(input logic [clk_regs_pkg::ADDR_W-1:0] a,
                               input logic [clk_regs_pkg::ADDR_W-1:0] b);
    hit = (a == b);
  endfunction

  logic status_sel;  // access addresses the status readback
  logic ctrl_sel;    // access addresses the output zero control

  always_comb begin
    status_sel = hit(reg_addr, clk_regs_pkg::STATUS_ADDR);
    ctrl_sel   = hit(reg_addr, clk_regs_pkg::DRV_CTRL_ADDR);
  end

  // ------------------------------------------------------------
  // output zero control register
  // ------------------------------------------------------------
  logic [clk_regs_pkg::DATA_W-1:0] drv_ctrl_reg;   // stored control byte
  logic [clk_regs_pkg::DATA_W-1:0] drv_ctrl_next;  // value after this cycle

  // only a write to the control address updates it; a write to the
  // status address has nowhere to land
  always_comb begin
    drv_ctrl_next = drv_ctrl_reg;
    // R7 status writes fall through untouched
    if (reg_wr && ctrl_sel) begin
      drv_ctrl_next = reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      drv_ctrl_reg <= clk_regs_pkg::DRV_CTRL_RESET;
    end else begin
      drv_ctrl_reg <= drv_ctrl_next;
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  logic [clk_regs_pkg::DATA_W-1:0] rdata_reg;   // read data held for the port
  logic [clk_regs_pkg::DATA_W-1:0] rdata_next;  // selected read data
  logic                            rvalid_reg;  // one-cycle read answer
  logic                            rvalid_next;

  // read data stays put between reads so a slow port can sample late
  always_comb begin
    rdata_next  = rdata_reg;
    rvalid_next = 1'b0;
    if (reg_rd) begin
      rvalid_next = 1'b1;
      if (status_sel) begin
        // R1 holdover, R2 reference, R3 vco, R4 ref two, R5 ref one, R6 lock
        rdata_next = {{(clk_regs_pkg::DATA_W - clk_regs_pkg::ST_COND_W){1'b0}}, cond_synced};
      end else if (ctrl_sel) begin
        rdata_next = drv_ctrl_reg;
      end else begin
        // unmapped addresses read as zero
        rdata_next = '0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg  <= '0;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata  = rdata_reg;
  assign reg_rvalid = rvalid_reg;

  // ------------------------------------------------------------
  // driver decode
  // ------------------------------------------------------------
  logic fmt_cmos;  // format field
  logic pol_hi;    // polarity upper bit
  logic pol_lo;    // polarity lower bit

  logic cmos_next;   // cmos mode after this cycle
  logic diff_next;   // differential driver enabled
  logic leg_a_next;  // leg a driven
  logic leg_b_next;  // leg b driven
  logic inv_a_next;  // leg a inverted
  logic inv_b_next;  // leg b inverted

  // decode is registered so the pads see one clean edge per write
  always_comb begin
    fmt_cmos = drv_ctrl_reg[clk_regs_pkg::OC_FORMAT_BIT];
    pol_hi   = drv_ctrl_reg[clk_regs_pkg::OC_POL_HI_BIT];
    pol_lo   = drv_ctrl_reg[clk_regs_pkg::OC_POL_LO_BIT];
    // R8 format bit chooses the driver type
    cmos_next = fmt_cmos;
    diff_next = !fmt_cmos;
    // R9 leg gating only applies in cmos mode
    leg_a_next = fmt_cmos && drv_ctrl_reg[clk_regs_pkg::OC_LEG_A_BIT];
    leg_b_next = fmt_cmos && drv_ctrl_reg[clk_regs_pkg::OC_LEG_B_BIT];
    // R10 lower bit always sets leg a; leg b depends on format
    inv_a_next = pol_lo;
    if (fmt_cmos) begin
      inv_b_next = pol_hi ^ pol_lo;
    end else begin
      // differential pair: leg b is the complement of leg a
      inv_b_next = !pol_lo;
    end
  end

  logic cmos_reg;
  logic diff_reg;
  logic leg_a_reg;
  logic leg_b_reg;
  logic inv_a_reg;
  logic inv_b_reg;

  // reset values match the decode of the control reset byte
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cmos_reg  <= 1'b0;
      diff_reg  <= 1'b1;
      leg_a_reg <= 1'b0;
      leg_b_reg <= 1'b0;
      inv_a_reg <= 1'b0;
      inv_b_reg <= 1'b1;
    end else begin
      cmos_reg  <= cmos_next;
      diff_reg  <= diff_next;
      leg_a_reg <= leg_a_next;
      leg_b_reg <= leg_b_next;
      inv_a_reg <= inv_a_next;
      inv_b_reg <= inv_b_next;
    end
  end

  assign output_zero_cmos_mode    = cmos_reg;
  assign output_zero_diff_enable  = diff_reg;
  assign output_zero_leg_a_enable = leg_a_reg;
  assign output_zero_leg_b_enable = leg_b_reg;
  assign output_zero_leg_a_invert = inv_a_reg;
  assign output_zero_leg_b_invert = inv_b_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  logic status_rd;  // read of the status address
  assign status_rd = reg_rd && status_sel;

  chk_holdover_read: assert property ( // R1
    status_rd |=> reg_rdata[5] == $past(cond_synced[5]))
    else $error("holdover bit does not match synchronised level");

  chk_ref_sel_read: assert property ( // R2
    status_rd |=> reg_rvalid && reg_rdata[4] == $past(cond_synced[4]))
    else $error("reference select bit wrong on read");

  chk_vco_read: assert property ( // R3
    status_rd |=> reg_rdata[3] == $past(cond_synced[3]))
    else $error("vco threshold bit wrong on read");

  chk_ref_two_read: assert property ( // R4
    status_rd |=> reg_rdata[2] == $past(cond_synced[2]))
    else $error("reference two threshold bit wrong on read");

  chk_ref_one_read: assert property ( // R5
    status_rd |=> reg_rdata[1] == $past(cond_synced[1]))
    else $error("reference one threshold bit wrong on read");

  chk_lock_settle: assert property ( // R6
    (pll_locked_in [*3]) ##1 status_rd |=> reg_rdata[0])
    else $error("lock bit not seen after three steady cycles");

  chk_status_ro: assert property ( // R7
    reg_wr && status_sel |=> $stable(drv_ctrl_reg))
    else $error("write to status changed control byte");

  chk_ctrl_readback: assert property ( // R8
    reg_rd && ctrl_sel |=> reg_rdata == $past(drv_ctrl_reg))
    else $error("control byte readback differs from stored byte");

  chk_format_mode: assert property ( // R8
    reg_wr && ctrl_sel |=> ##1 output_zero_cmos_mode == $past(reg_wdata[7], 2)
                               && output_zero_diff_enable != output_zero_cmos_mode)
    else $error("driver format not following written bit");

  chk_leg_gating: assert property ( // R9
    reg_wr && ctrl_sel ##1 !reg_wr |=> output_zero_leg_b_enable
      == ($past(reg_wdata[7], 2) && $past(reg_wdata[6], 2)))
    else $error("leg b enable wrong for written field");

  chk_leg_a_gating: assert property ( // R9
    reg_wr && ctrl_sel ##1 !reg_wr |=> output_zero_leg_a_enable
      == ($past(reg_wdata[7], 2) && $past(reg_wdata[5], 2)))
    else $error("leg a enable wrong for written field");

  // the cmos legs must stay off while the differential driver owns the pins
  chk_diff_legs_off: assert property ( // R9
    !output_zero_cmos_mode |-> !output_zero_leg_a_enable && !output_zero_leg_b_enable)
    else $error("cmos leg enabled in differential mode");

  chk_polarity_pair: assert property ( // R10
    !output_zero_cmos_mode |-> output_zero_leg_a_invert != output_zero_leg_b_invert)
    else $error("differential legs share polarity");

  // cmos leg a follows the lower polarity bit, leg b the xor of both polarity bits
  chk_cmos_polarity: assert property ( // R10
    reg_wr && ctrl_sel && reg_wdata[7] |=> ##1 output_zero_leg_a_invert == $past(reg_wdata[3], 2)
      && output_zero_leg_b_invert == ($past(reg_wdata[4], 2) ^ $past(reg_wdata[3], 2)))
    else $error("cmos leg polarity wrong for written field");

  chk_read_answer: assert property ( // R11
    reg_rd |=> reg_rvalid)
    else $error("read not answered one cycle later");

  chk_rvalid_pulse: assert property ( // R11
    !reg_rd |=> !reg_rvalid)
    else $error("read answer without a read");

  // a single-stage crossing would already show the new level here
  chk_sync_delay: assert property ( // R11
    $rose(holdover_active_in) |=> !cond_synced[5])
    else $error("holdover level crossed without synchroniser");

  cov_status_read: cover property (status_rd ##1 reg_rdata[0]);
  cov_cmos_both: cover property (output_zero_leg_a_enable && output_zero_leg_b_enable);
  cov_status_write: cover property (reg_wr && status_sel);
  cov_unmapped_read: cover property (reg_rd && !status_sel && !ctrl_sel);
  cov_joint_access: cover property (reg_wr && reg_rd && ctrl_sel);

endmodule // clock_status_and_output_format_regs

// file: tb/clock_status_and_output_format_regs_tb.sv
// self-checking bench for the status readback and output zero driver control registers
`timescale 1ns/1ps

module clock_status_and_output_format_regs_tb;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic                               sys_clk   = 1'b0;  // 40 mhz port clock
  logic                               resetn    = 1'b0;  // async reset, active low
  logic [clk_regs_pkg::ADDR_W-1:0]    reg_addr  = '0;    // register address
  logic [clk_regs_pkg::DATA_W-1:0]    reg_wdata = '0;    // write data
  logic                               reg_wr    = 1'b0;  // write strobe
  logic                               reg_rd    = 1'b0;  // read strobe
  logic [5:0]                         cond_drv  = '0;    // monitored levels, bit order as status
  logic [clk_regs_pkg::DATA_W-1:0]    reg_rdata;         // read answer data
  logic                               reg_rvalid;        // read answer pulse
  wire logic [5:0]                    drv;               // {cmos, diff, a_en, b_en, a_inv, b_inv}
  logic [7:0]                         rd_val;            // last value read
  int                                 err_total = 0;     // mismatches seen
  int                                 cmp_count = 0;     // comparisons made
  // one control byte and the driver decode it must give
  typedef struct packed { logic [7:0] wdata; logic [5:0] drv; } row_s;
  row_s rows [9] = '{'{8'h00, 6'b010001}, '{8'h08, 6'b010010}, '{8'h7f, 6'b010010},
                     '{8'h80, 6'b100000}, '{8'ha8, 6'b101011}, '{8'hd0, 6'b100101},
                     '{8'he0, 6'b101100}, '{8'hf8, 6'b101110}, '{8'hf7, 6'b101101}};

  // half period of 12.5 ns gives 25 ns
  always #12.5 sys_clk = ~sys_clk;

  clock_status_and_output_format_regs dut_u (
    .sys_clk                  (sys_clk),
    .resetn                   (resetn),
    .reg_addr                 (reg_addr),
    .reg_wdata                (reg_wdata),
    .reg_wr                   (reg_wr),
    .reg_rd                   (reg_rd),
    .reg_rdata                (reg_rdata),
    .reg_rvalid               (reg_rvalid),
    .holdover_active_in       (cond_drv[5]),
    .ref_two_selected_in      (cond_drv[4]),
    .vco_above_thresh_in      (cond_drv[3]),
    .ref_two_above_thresh_in  (cond_drv[2]),
    .ref_one_above_thresh_in  (cond_drv[1]),
    .pll_locked_in            (cond_drv[0]),
    .output_zero_cmos_mode    (drv[5]),
    .output_zero_diff_enable  (drv[4]),
    .output_zero_leg_a_enable (drv[3]),
    .output_zero_leg_b_enable (drv[2]),
    .output_zero_leg_a_invert (drv[1]),
    .output_zero_leg_b_invert (drv[0])
  );

  // ----------------------------------------
  // compare and closing tasks
  // ----------------------------------------
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_drv(input string what, input logic [5:0] exp);
    cmp_count++;
    if (drv !== exp) begin
      err_total++;
      $display("BAD %s expected %b seen %b", what, exp, drv);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // register port tasks
  // ----------------------------------------
  // one-cycle write strobe, taken at the following edge
  task automatic reg_write(input logic [9:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  // one-cycle read strobe, answer waited for under a bound
  task automatic reg_read(input logic [9:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      #1;
      if (reg_rvalid === 1'b1) break;
      if (i == 3) begin
        err_total++;
        $display("BAD rvalid expected 1 seen %b", reg_rvalid);
        complete_run();
      end
      @(posedge sys_clk);
    end
    d = reg_rdata;
  endtask

  // driver outputs follow one edge after the control byte
  task automatic settle_drv;
    @(posedge sys_clk);
    #1;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    #1;
    chk_drv("drivers in reset", 6'b010001);
    chk_byte("rvalid in reset", 8'h00, {7'h00, reg_rvalid});
    @(posedge sys_clk);
    resetn <= 1'b1;
    reg_read(clk_regs_pkg::DRV_CTRL_ADDR, rd_val);
    chk_byte("control reset value", clk_regs_pkg::DRV_CTRL_RESET, rd_val);
    @(posedge sys_clk);
    #1;
    chk_byte("read data held", clk_regs_pkg::DRV_CTRL_RESET, reg_rdata);
    chk_byte("rvalid after answer", 8'h00, {7'h00, reg_rvalid});
    reg_read(clk_regs_pkg::STATUS_ADDR, rd_val);
    chk_byte("status after reset", 8'h00, rd_val);
    $display("test reset done");
    // ordinary control byte cases
    foreach (rows[i]) begin
      reg_write(clk_regs_pkg::DRV_CTRL_ADDR, rows[i].wdata);
      settle_drv();
      chk_drv("driver decode", rows[i].drv);
      reg_read(clk_regs_pkg::DRV_CTRL_ADDR, rd_val);
      chk_byte("control readback", rows[i].wdata, rd_val);
    end
    $display("test control rows done");
    // each monitored condition alone, then all, then none
    for (int b = 0; b <= 7; b++) begin
      @(posedge sys_clk);
      cond_drv <= (b < 6) ? 6'(1 << b) : ((b == 6) ? 6'h3f : 6'h00);
      repeat (4) @(posedge sys_clk);
      reg_read(clk_regs_pkg::STATUS_ADDR, rd_val);
      chk_byte("status bits", {2'b00, cond_drv}, rd_val);
    end
    $display("test status bits done");
    // write to the status register and to an unmapped place change nothing
    @(posedge sys_clk);
    cond_drv <= 6'h15;
    repeat (4) @(posedge sys_clk);
    reg_write(clk_regs_pkg::STATUS_ADDR, 8'hff);
    reg_read(clk_regs_pkg::STATUS_ADDR, rd_val);
    chk_byte("status after write", 8'h15, rd_val);
    reg_write(10'h0f1, 8'h80);
    settle_drv();
    chk_drv("drivers after stray write", 6'b101101);
    reg_read(10'h0f1, rd_val);
    chk_byte("unmapped read", 8'h00, rd_val);
    $display("test read only done");
    // read and write in the same cycle: read returns the old byte
    @(posedge sys_clk);
    reg_addr  <= clk_regs_pkg::DRV_CTRL_ADDR;
    reg_wdata <= 8'ha8;
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    #1;
    chk_byte("read during write", 8'hf7, reg_rdata);
    settle_drv();
    chk_drv("drivers after joint access", 6'b101011);
    $display("test joint access done");
    // reset in mid-run restores the default byte
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk_drv("drivers in second reset", 6'b010001);
    @(posedge sys_clk);
    resetn <= 1'b1;
    reg_read(clk_regs_pkg::DRV_CTRL_ADDR, rd_val);
    chk_byte("control after second reset", 8'h62, rd_val);
    $display("test second reset done");
    complete_run();
  end
endmodule  // clock_status_and_output_format_regs_tb
